//--- hw/tvc_top.sv
// tuner command decoder and band, standard, AV, AFC and standby output control
`timescale 1ns/1ps
module tvc_top
    import tvc_pkg::*;
#(
    parameter int PROG_CYC = AFC_PROG_CYC,
    parameter int TUNE_CYC = AFC_TUNE_CYC,
    parameter int RESET_CYC = AFC_RESET_CYC
) (
    input wire logic clk, // 200 MHz clock
    input wire logic rst_b, // async power-on reset, active low
    input wire logic [4:0] dataWord, // parallel command pins, bit 0 lsb
    input wire logic kbdCmdValid, // keyboard command pulse
    input wire logic [4:0] kbdCmd, // keyboard command code, same coding
    input wire logic kbdBandSeq, // band-sequence key pulse
    input wire logic kbdStdSeq, // multi-standard key pulse
    input wire logic kbdOnOff, // on/off key pulse
    input wire logic kbdTuneHeld, // tune up or down key held
    input wire logic [3:0] bandSkip_b, // band skip pins, low skips the band
    input wire logic [OPT_COLS-1:0] colStrobe_b, // keyboard column strobes
    input wire logic optionLine, // option select pin
    output logic [3:0] bandSel, // one-hot band outputs
    output logic [1:0] msOut, // coded standard outputs
    output logic avFirstOut, // first AV pin drive level
    output logic avFirstOe, // first AV pin pull-down enable
    output logic avSecondOut, // second AV pin drive level
    output logic avSecondOe, // second AV pin pull-down enable
    output logic afcDefeat_b, // low while AFC is defeated
    output logic standbyOut, // high in standby or off
    output logic [4:0] progNum, // selected program
    output logic skipDefeat, // program skip defeated
    output logic twentyProg, // 20-program option active
    output logic decadeMode, // decade mode, low in prefix mode or the 16-program option
    output logic powerOn // device in on state
);
    tvc_opt_if opt ();

    tvc_option_scan u_scan (
        .clk(clk),
        .rst_b(rst_b),
        .colStrobe_b(colStrobe_b),
        .optionLine(optionLine),
        .opt(opt)
    );

    logic [4:0] dataMeta_r, dataSync_r, dataPrev_r;
    tvc_pwr_type pwr_r, pwr_nxt;
    logic [4:0] prog_r, prog_nxt;
    logic [1:0] band_r, band_nxt, ms_r, ms_nxt;
    logic prefix_r, prefix_nxt, armed_r, armed_nxt, tunePrev_r, tunePrev_nxt;
    logic started_r, started_nxt;
    logic av1_r, av1_nxt, av2_r, av2_nxt;
    logic afcLoad;
    logic [AFC_W-1:0] afcCount;
    logic afcBusy;
    logic cmdValid, dataTake, isProg, twenty, decMode, wakeCmd, tuneRelease;
    logic [4:0] cmd, target, seqUp, seqDown;
    logic [1:0] bandStep;
    logic [3:0] bandSkipMeta_r, bandSkipSync_r;
    logic [2:0] optOut_r, optOut_nxt;

    tvc_hold_timer #(.WIDTH(AFC_W)) u_afc (
        .clk(clk),
        .rst_b(rst_b),
        .load(afcLoad),
        .loadCount(afcCount),
        .busy(afcBusy)
    );

    assign twenty = opt.optBits[OPT_TWENTY];
    assign decMode = twenty & ~opt.optBits[OPT_PREFIX];

    // data word taken once when stable and armed; end code rearms
    // the host is not in step with this clock, so a word must read alike on two edges
    always_comb begin
        dataTake = armed_r && dataSync_r == dataPrev_r && dataSync_r != CMD_EOT && dataSync_r != CMD_IDLE;
        cmdValid = kbdCmdValid | (dataTake & ~kbdCmdValid);
        cmd = kbdCmdValid ? kbdCmd : dataSync_r;
        armed_nxt = armed_r;
        if (dataSync_r == dataPrev_r && dataSync_r == CMD_EOT)
            armed_nxt = 1'b1;
        else if (dataTake && !kbdCmdValid)
            armed_nxt = 1'b0;
    end

    // program decode; 14-16 fall out as no-ops in 20-option
    always_comb begin
        isProg = 1'b0;
        target = cmd;
        if (cmd != CMD_EOT && cmd <= CMD_PROG_LAST_DIGIT) begin
            isProg = 1'b1;
            if (twenty && prefix_r)
                target = cmd + PROG_DECADE;
        end else if (cmd == CMD_PROG0 && twenty) begin
            isProg = 1'b1;
            target = prefix_r ? PROG_DECADE : 5'h00;
        end else if (!twenty && cmd >= CMD_PROG0 && cmd <= CMD_PROG_MAX16) begin
            isProg = 1'b1;
        end
    end

    // commands that wake the set from standby
    always_comb begin
        wakeCmd = 1'b0;
        if (cmdValid) begin
            if (isProg || cmd == CMD_ON_STBY || cmd == CMD_SEQ_UP || cmd == CMD_SEQ_DOWN)
                wakeCmd = 1'b1;
            else if (twenty && (cmd == CMD_DEC_DOWN || cmd == CMD_DEC_UP || cmd == CMD_PREFIX))
                wakeCmd = 1'b1;
        end
    end

    // memory sequence neighbours; program 0 exists only in the 20-program option
    always_comb begin
        if (twenty) begin
            seqUp = prog_r >= PROG_TOP20 ? 5'h00 : prog_r + 5'h01;
            seqDown = prog_r == 5'h00 ? PROG_TOP20 : prog_r - 5'h01;
        end else begin
            seqUp = prog_r >= PROG_TOP16 ? PROG_RESET : prog_r + 5'h01;
            seqDown = prog_r <= PROG_RESET ? PROG_TOP16 : prog_r - 5'h01;
        end
    end

    // next band not skipped, nearest first; all four skipped keeps the band
    always_comb begin
        bandStep = band_r;
        for (int k = 3; k >= 1; k--) begin
            if (bandSkipSync_r[2'(band_r + 2'(k))])
                bandStep = 2'(band_r + 2'(k));
        end
    end

    // release is seen on the first edge the key reads low, against the registered key level
    assign tuneRelease = tunePrev_r & ~kbdTuneHeld;

    always_comb begin
        pwr_nxt = pwr_r;
        prog_nxt = prog_r;
        band_nxt = band_r;
        ms_nxt = ms_r;
        prefix_nxt = prefix_r;
        started_nxt = started_r;
        tunePrev_nxt = kbdTuneHeld;
        afcLoad = 1'b0;
        afcCount = AFC_W'(PROG_CYC);
        // power-up state waits for the first full option scan
        if (!started_r && opt.optValid) begin
            started_nxt = 1'b1;
            pwr_nxt = opt.optBits[OPT_PWR_STBY] ? PWR_STBY_PD : PWR_OFF;
        end
        unique case (pwr_r)
            PWR_OFF: begin
                if (kbdOnOff) begin
                    pwr_nxt = PWR_ON;
                    prog_nxt = PROG_RESET;
                    afcLoad = 1'b1;
                    afcCount = AFC_W'(RESET_CYC);
                end
            end
            PWR_STBY_PD, PWR_STBY_ON: begin
                // a waking program command from PWR_STBY_ON also selects its program; other waking commands are not executed further
                if (kbdOnOff && pwr_r == PWR_STBY_ON) begin
                    pwr_nxt = PWR_OFF;
                end else if (kbdOnOff || wakeCmd) begin
                    pwr_nxt = PWR_ON;
                    afcLoad = 1'b1;
                    afcCount = AFC_W'(RESET_CYC);
                    prefix_nxt = 1'b0;
                    if (pwr_r == PWR_STBY_PD)
                        prog_nxt = PROG_RESET;
                    else if (cmdValid && isProg)
                        prog_nxt = target;
                end
            end
            PWR_ON: begin
                if (kbdOnOff) begin
                    pwr_nxt = PWR_OFF;
                end else if (cmdValid && (cmd == CMD_STBY || cmd == CMD_ON_STBY)) begin
                    pwr_nxt = PWR_STBY_ON;
                    prefix_nxt = 1'b0;
                end else if (cmdValid) begin
                    prefix_nxt = 1'b0;
                    if (isProg) begin
                        prog_nxt = target;
                        afcLoad = 1'b1;
                    end else if (twenty && !decMode && cmd == CMD_PREFIX) begin
                        prefix_nxt = 1'b1;
                    end else if (decMode && cmd == CMD_DEC_UP && prog_r < PROG_DECADE) begin
                        prog_nxt = prog_r + PROG_DECADE;
                        afcLoad = 1'b1;
                    end else if (decMode && cmd == CMD_DEC_DOWN && prog_r >= PROG_DECADE) begin
                        prog_nxt = prog_r - PROG_DECADE;
                        afcLoad = 1'b1;
                    end else if (cmd == CMD_SEQ_UP) begin
                        afcLoad = 1'b1;
                        prog_nxt = seqUp;
                    end else if (cmd == CMD_SEQ_DOWN) begin
                        afcLoad = 1'b1;
                        prog_nxt = seqDown;
                    end
                end
                if (kbdBandSeq)
                    band_nxt = bandStep;
                if (kbdStdSeq)
                    ms_nxt = ms_r + 2'h1;
                if (tuneRelease) begin
                    afcLoad = 1'b1;
                    afcCount = AFC_W'(TUNE_CYC);
                end
            end
        endcase
    end

    // AV decode from program and options
    // follows prog_nxt so the AV pins switch on the same edge as the program
    always_comb begin
        if (opt.optBits[OPT_AV2]) begin
            av1_nxt = prog_nxt == AV2_FIRST || prog_nxt == AV2_BOTH;
            av2_nxt = prog_nxt == AV2_SECOND || prog_nxt == AV2_BOTH;
        end else begin
            av1_nxt = prog_nxt == (twenty ? AV1_FIRST20 : AV1_FIRST16);
            av2_nxt = prog_nxt == (twenty ? AV1_SECOND20 : AV1_SECOND16);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dataMeta_r <= CMD_IDLE;
            dataSync_r <= CMD_IDLE;
            dataPrev_r <= CMD_IDLE;
            bandSkipMeta_r <= 4'hf;
            bandSkipSync_r <= 4'hf;
            pwr_r <= PWR_OFF;
            prog_r <= PROG_RESET;
            band_r <= BAND_RESET;
            ms_r <= MS_RESET;
            prefix_r <= 1'b0;
            armed_r <= 1'b1;
            tunePrev_r <= 1'b0;
            started_r <= 1'b0;
            av1_r <= 1'b0;
            av2_r <= 1'b0;
        end else begin
            dataMeta_r <= dataWord;
            dataSync_r <= dataMeta_r;
            dataPrev_r <= dataSync_r;
            bandSkipMeta_r <= bandSkip_b;
            bandSkipSync_r <= bandSkipMeta_r;
            pwr_r <= pwr_nxt;
            prog_r <= prog_nxt;
            band_r <= band_nxt;
            ms_r <= ms_nxt;
            prefix_r <= prefix_nxt;
            armed_r <= armed_nxt;
            tunePrev_r <= tunePrev_nxt;
            started_r <= started_nxt;
            av1_r <= av1_nxt;
            av2_r <= av2_nxt;
        end
    end

    // power-on hold: timer idle at reset, so the first 1.1 s is counted here
    logic [AFC_W-1:0] porCount_r, porCount_nxt;
    always_comb begin
        porCount_nxt = porCount_r;
        if (porCount_r != AFC_W'(RESET_CYC))
            porCount_nxt = porCount_r + 1'b1;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            porCount_r <= '0;
        else
            porCount_r <= porCount_nxt;
    end

    // option levels re-registered so these outputs leave straight from flops
    always_comb begin
        optOut_nxt = {opt.optBits[OPT_SKIP_DEF], twenty, decMode};
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            optOut_r <= '0;
        else
            optOut_r <= optOut_nxt;
    end

    assign bandSel = 4'h1 << band_r;
    assign msOut = (pwr_r == PWR_ON) ? ms_r : 2'h0;
    // open drain: pulled low for 0, released for 1
    assign avFirstOut = 1'b0;
    assign avFirstOe = ~av1_r;
    assign avSecondOut = 1'b0;
    assign avSecondOe = ~av2_r;
    // tune key level joins directly so the defeat starts on the press itself
    assign afcDefeat_b = ~(afcBusy | kbdTuneHeld | porCount_r != AFC_W'(RESET_CYC));
    assign standbyOut = pwr_r != PWR_ON;
    assign progNum = prog_r;
    assign skipDefeat = optOut_r[2];
    assign twentyProg = optOut_r[1];
    assign decadeMode = optOut_r[0];
    assign powerOn = pwr_r == PWR_ON;
endmodule : tvc_top

//--- hw/tvc_pkg.sv
// shared constants, commands and state types for the tuner command/output block
package tvc_pkg;
    localparam logic [4:0] CMD_EOT = 5'h00;
    localparam logic [4:0] CMD_PROG_LAST_DIGIT = 5'h09;
    localparam logic [4:0] CMD_PROG0 = 5'h0a;
    localparam logic [4:0] CMD_DEC_DOWN = 5'h0b;
    localparam logic [4:0] CMD_DEC_UP = 5'h0c;
    localparam logic [4:0] CMD_PREFIX = 5'h0d;
    localparam logic [4:0] CMD_PROG_MAX16 = 5'h10;
    localparam logic [4:0] CMD_SEQ_UP = 5'h1a;
    localparam logic [4:0] CMD_SEQ_DOWN = 5'h1b;
    localparam logic [4:0] CMD_ON_STBY = 5'h1c;
    localparam logic [4:0] CMD_STBY = 5'h1d;
    localparam logic [4:0] CMD_IDLE = 5'h1f;

    // option column positions on the option line, column 1 at bit 0
    localparam int OPT_TWENTY = 0;
    localparam int OPT_AV2 = 1;
    localparam int OPT_PWR_STBY = 2;
    localparam int OPT_PREFIX = 3;
    localparam int OPT_SKIP_DEF = 4;
    localparam int OPT_COLS = 5;

    localparam logic [4:0] PROG_RESET = 5'h01;
    localparam logic [4:0] PROG_TOP16 = 5'h10;
    localparam logic [4:0] PROG_TOP20 = 5'h13;
    localparam logic [4:0] PROG_DECADE = 5'h0a;
    localparam logic [4:0] AV1_FIRST16 = 5'h10;
    localparam logic [4:0] AV1_FIRST20 = 5'h00;
    localparam logic [4:0] AV1_SECOND16 = 5'h0f;
    localparam logic [4:0] AV1_SECOND20 = 5'h13;
    localparam logic [4:0] AV2_FIRST = 5'h08;
    localparam logic [4:0] AV2_SECOND = 5'h07;
    localparam logic [4:0] AV2_BOTH = 5'h06;

    // band index: 0 VHF III, 1 UHF, 2 VHF I, 3 CATV (sequence order)
    localparam logic [1:0] BAND_RESET = 2'h0;
    localparam logic [1:0] MS_RESET = 2'h0;

    localparam int CLK_KHZ = 200000;
    localparam int AFC_PROG_MS = 500;
    localparam int AFC_TUNE_MS = 1000;
    localparam int AFC_RESET_MS = 1100;
    localparam int AFC_PROG_CYC = AFC_PROG_MS * CLK_KHZ;
    localparam int AFC_TUNE_CYC = AFC_TUNE_MS * CLK_KHZ;
    localparam int AFC_RESET_CYC = AFC_RESET_MS * CLK_KHZ;
    localparam int AFC_W = 28;

    typedef enum logic [3:0] {
        PWR_OFF = 4'h1,
        PWR_STBY_PD = 4'h2,
        PWR_STBY_ON = 4'h4,
        PWR_ON = 4'h8
    } tvc_pwr_type;
endpackage : tvc_pkg

//--- hw/tvc_opt_if.sv
// option-scan results passed from the scanner to the command core
`timescale 1ns/1ps
interface tvc_opt_if;
    logic [4:0] optBits;
    logic optValid;
    modport scan (output optBits, output optValid);
    modport core (input optBits, input optValid);
endinterface : tvc_opt_if

//--- hw/tvc_option_scan.sv
// option line scanner: one latch per keyboard column
`timescale 1ns/1ps
module tvc_option_scan
    import tvc_pkg::*;
(
    input wire logic clk, // 200 MHz clock
    input wire logic rst_b, // async reset, active low
    input wire logic [OPT_COLS-1:0] colStrobe_b, // column drive, low while scanned
    input wire logic optionLine, // option line pin
    tvc_opt_if.scan opt // latched option bits
);
    logic lineMeta_r, lineSync_r;
    logic [OPT_COLS-1:0] strobeD1_r, strobeD2_r, opt_r, seen_r;
    logic [OPT_COLS-1:0] opt_nxt, seen_nxt;

    // strobes delayed two cycles to line up with the synchronised line
    always_comb begin
        opt_nxt = opt_r;
        seen_nxt = seen_r;
        for (int i = 0; i < OPT_COLS; i++) begin
            // each column latched on its own: any number may be active
            if (!strobeD2_r[i]) begin
                opt_nxt[i] = ~lineSync_r;
                seen_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lineMeta_r <= 1'b1;
            lineSync_r <= 1'b1;
            strobeD1_r <= '1;
            strobeD2_r <= '1;
            opt_r <= '0;
            seen_r <= '0;
        end else begin
            lineMeta_r <= optionLine;
            lineSync_r <= lineMeta_r;
            strobeD1_r <= colStrobe_b;
            strobeD2_r <= strobeD1_r;
            opt_r <= opt_nxt;
            seen_r <= seen_nxt;
        end
    end

    assign opt.optBits = opt_r;
    assign opt.optValid = &seen_r;
endmodule : tvc_option_scan

//--- hw/tvc_hold_timer.sv
// retriggerable down-counter that keeps a hold active for a loaded time
`timescale 1ns/1ps
module tvc_hold_timer #(
    parameter int WIDTH = 28
) (
    input wire logic clk, // 200 MHz clock
    input wire logic rst_b, // async reset, active low
    input wire logic load, // start or extend the hold
    input wire logic [WIDTH-1:0] loadCount, // cycles to hold from now
    output logic busy // hold still running
);
    logic [WIDTH-1:0] count_r, count_nxt;

    // a shorter new request never cuts an older, longer hold
    always_comb begin
        count_nxt = count_r;
        if (count_r != '0)
            count_nxt = count_r - 1'b1;
        if (load && loadCount > count_nxt)
            count_nxt = loadCount;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end

    assign busy = count_r != '0;
endmodule : tvc_hold_timer

//--- verif/tvc_chk.sv
// assertion checker for the tuner command and output block
`timescale 1ns/1ps
module tvc_chk
    import tvc_pkg::*;
#(
    parameter int PROG_CYC = AFC_PROG_CYC,
    parameter int TUNE_CYC = AFC_TUNE_CYC,
    parameter int RESET_CYC = AFC_RESET_CYC
) (
    input wire logic clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic kbdBandSeq, // band key pulse
    input wire logic kbdStdSeq, // standard key pulse
    input wire logic kbdTuneHeld, // tune key level
    input wire logic [3:0] bandSkip_b, // band skip pins
    input wire logic [3:0] bandSel, // band outputs
    input wire logic [1:0] msOut, // standard outputs
    input wire logic avFirstOut, // first AV drive level
    input wire logic avFirstOe, // first AV pull-down enable
    input wire logic avSecondOut, // second AV drive level
    input wire logic avSecondOe, // second AV pull-down enable
    input wire logic afcDefeat_b, // AFC defeat, active low
    input wire logic standbyOut, // standby output
    input wire logic [4:0] progNum, // selected program
    input wire logic twentyProg, // 20-program option
    input wire logic powerOn // on state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    band_only_key_a: assert property (!kbdBandSeq |=> $stable(bandSel))
        else $error("band changed without band key");
    band_skip_a: assert property (kbdBandSeq && powerOn && bandSkip_b == 4'hd && bandSel == 4'h1 |=> bandSel == 4'h4)
        else $error("skipped band not passed over");
    ms_count_a: assert property (kbdStdSeq && powerOn |=> msOut == $past(msOut) + 2'h1)
        else $error("standard outputs did not count");
    ms_low_off_a: assert property (!powerOn |-> msOut == 2'h0)
        else $error("standard outputs high while not on");
    av_open_drain_a: assert property (avFirstOut == 1'b0 && avSecondOut == 1'b0)
        else $error("AV pin driven high");
    av_others_low_a: assert property (progNum >= 5'h01 && progNum <= 5'h05 |-> avFirstOe && avSecondOe)
        else $error("AV pin released on an ordinary program");
    afc_prog_change_a: assert property ($changed(progNum) && powerOn |-> !afcDefeat_b)
        else $error("AFC not defeated on program change");
    afc_tune_held_a: assert property (kbdTuneHeld && powerOn |-> !afcDefeat_b)
        else $error("AFC not defeated while tuning");
    afc_tune_tail_a: assert property ($fell(kbdTuneHeld) && powerOn |-> ##2 (!afcDefeat_b) [*8])
        else $error("AFC defeat dropped early after tune release");
    afc_reset_a: assert property ($rose(rst_b) |-> (!afcDefeat_b) [*8])
        else $error("AFC not defeated after reset");
    stby_pin_a: assert property (standbyOut == !powerOn)
        else $error("standby output disagrees with state");
    prog_range_a: assert property (!twentyProg && powerOn |-> progNum >= 5'h01 && progNum <= 5'h10)
        else $error("program outside 16-program range");
endmodule : tvc_chk

bind tvc_top tvc_chk #(.PROG_CYC(PROG_CYC), .TUNE_CYC(TUNE_CYC), .RESET_CYC(RESET_CYC)) chk (.clk(clk),
    .rst_b(rst_b), .kbdBandSeq(kbdBandSeq), .kbdStdSeq(kbdStdSeq), .kbdTuneHeld(kbdTuneHeld),
    .bandSkip_b(bandSkip_b), .bandSel(bandSel), .msOut(msOut), .avFirstOut(avFirstOut), .avSecondOut(avSecondOut),
    .avFirstOe(avFirstOe), .avSecondOe(avSecondOe),
    .afcDefeat_b(afcDefeat_b), .standbyOut(standbyOut), .progNum(progNum), .twentyProg(twentyProg),
    .powerOn(powerOn));

//--- verif/tvc_host_model.sv
// host processor model driving the parallel command pins
`timescale 1ns/1ps
module tvc_host_model (
    input wire logic clk, // clock
    output logic [4:0] dataWord // command pins, released lines read all-high
);
    initial dataWord = 5'h1f;

    // end-code gap scaled down, the real host spacing would make the run far too long
    task automatic send(input logic [4:0] cmd);
        @(negedge clk);
        dataWord = cmd;
        repeat (8) @(negedge clk);
        dataWord = 5'h00;
        repeat (8) @(negedge clk);
        dataWord = 5'h1f;
    endtask : send
endmodule : tvc_host_model

//--- verif/tvc_top_tb.sv
// self-checking testbench for the tuner command and output block
`timescale 1ns/1ps
module tvc_top_tb;
    import tvc_pkg::*;
    logic clk, rst_b, kbdCmdValid, kbdBandSeq, kbdStdSeq, kbdOnOff, kbdTuneHeld, optionLine;
    logic avFirstOut, avFirstOe, avSecondOut, avSecondOe, afcDefeat_b, standbyOut;
    logic skipDefeat, twentyProg, decadeMode, powerOn;
    logic [4:0] dataWord, kbdCmd, colStrobe_b, progNum, optDiodes;
    logic [3:0] bandSkip_b, bandSel;
    logic [1:0] msOut;
    logic [4:0] bandExp [3] = '{5'h04, 5'h08, 5'h01};
    logic [4:0] avProg [4] = '{5'h08, 5'h07, 5'h06, 5'h05};
    logic [4:0] avExp [4] = '{5'h01, 5'h02, 5'h00, 5'h03};
    int n_fail = 0;
    int n_checks = 0;

    tvc_top #(.PROG_CYC(20), .TUNE_CYC(40), .RESET_CYC(44)) dut (.clk(clk), .rst_b(rst_b), .dataWord(dataWord),
        .kbdCmdValid(kbdCmdValid), .kbdCmd(kbdCmd), .kbdBandSeq(kbdBandSeq), .kbdStdSeq(kbdStdSeq),
        .kbdOnOff(kbdOnOff), .kbdTuneHeld(kbdTuneHeld), .bandSkip_b(bandSkip_b), .colStrobe_b(colStrobe_b),
        .optionLine(optionLine), .bandSel(bandSel), .msOut(msOut), .avFirstOut(avFirstOut), .avFirstOe(avFirstOe),
        .avSecondOut(avSecondOut), .avSecondOe(avSecondOe), .afcDefeat_b(afcDefeat_b), .standbyOut(standbyOut),
        .progNum(progNum), .skipDefeat(skipDefeat), .twentyProg(twentyProg), .decadeMode(decadeMode),
        .powerOn(powerOn));
    tvc_host_model host (.clk(clk), .dataWord(dataWord));

    // several diodes at once pull the line low on their own columns
    assign optionLine = ~|(~colStrobe_b & optDiodes);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial colStrobe_b = 5'h1e;
    always @(negedge clk) colStrobe_b <= {colStrobe_b[3:0], colStrobe_b[4]};

    task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic kb(input int k);
        @(negedge clk);
        {kbdOnOff, kbdStdSeq, kbdBandSeq} = 3'(1 << k);
        @(negedge clk);
        {kbdOnOff, kbdStdSeq, kbdBandSeq} = 3'h0;
        repeat (3) @(negedge clk);
    endtask : kb

    task automatic kc(input logic [4:0] code);
        @(negedge clk);
        kbdCmdValid = 1'b1;
        kbdCmd = code;
        @(negedge clk);
        kbdCmdValid = 1'b0;
        repeat (3) @(negedge clk);
    endtask : kc

    task automatic rst(input logic [4:0] opts);
        @(negedge clk);
        optDiodes = opts;
        rst_b = 1'b0;
        repeat (10) @(negedge clk);
        chk("afc", 5'h00, 5'(afcDefeat_b));
        chk("standby", 5'h01, 5'(standbyOut));
        chk("band", 5'h01, 5'(bandSel));
        rst_b = 1'b1;
        repeat (60) @(negedge clk);
    endtask : rst

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    initial begin
        rst_b = 1'b0;
        {kbdCmdValid, kbdTuneHeld} = 2'h0;
        {kbdOnOff, kbdStdSeq, kbdBandSeq} = 3'h0;
        kbdCmd = 5'h00;
        bandSkip_b = 4'hd;
        optDiodes = 5'h05;
        // twenty programs, standby power-up, decade mode, AV option 1
        rst(5'h05);
        chk("twenty", 5'h01, 5'(twentyProg));
        chk("decade", 5'h01, 5'(decadeMode));
        chk("powerOn", 5'h00, 5'(powerOn));
        host.send(5'h05);
        chk("prog", 5'h01, progNum);
        chk("avOe", 5'h03, 5'({avFirstOe, avSecondOe}));
        chk("avOut", 5'h00, 5'({avFirstOut, avSecondOut}));
        host.send(5'h0a);
        chk("prog", 5'h00, progNum);
        chk("avOe", 5'h01, 5'({avFirstOe, avSecondOe}));
        host.send(5'h0c);
        chk("prog", 5'h0a, progNum);
        host.send(5'h09);
        host.send(5'h0c);
        chk("avOe", 5'h02, 5'({avFirstOe, avSecondOe}));
        host.send(5'h0b);
        host.send(5'h0e);
        chk("prog", 5'h09, progNum);
        $display("test twenty program done");
        for (int i = 0; i < 3; i++) begin
            kb(0);
            chk("band", bandExp[i], 5'(bandSel));
        end
        for (int i = 0; i < 4; i++) begin
            kb(1);
            chk("msOut", 5'((i + 1) % 4), 5'(msOut));
        end
        host.send(5'h1d);
        chk("standby", 5'h01, 5'(standbyOut));
        chk("msOut", 5'h00, 5'(msOut));
        host.send(5'h03);
        chk("prog", 5'h03, progNum);
        host.send(5'h1c);
        chk("standby", 5'h01, 5'(standbyOut));
        host.send(5'h1a);
        chk("prog", 5'h03, progNum);
        repeat (60) @(negedge clk);
        chk("afc", 5'h01, 5'(afcDefeat_b));
        kbdTuneHeld = 1'b1;
        repeat (5) @(negedge clk);
        chk("afc", 5'h00, 5'(afcDefeat_b));
        kbdTuneHeld = 1'b0;
        repeat (30) @(negedge clk);
        chk("afc", 5'h00, 5'(afcDefeat_b));
        repeat (20) @(negedge clk);
        chk("afc", 5'h01, 5'(afcDefeat_b));
        $display("test band standard standby done");
        // sixteen programs, off power-up, AV option 2, skip defeated
        rst(5'h12);
        chk("skipDef", 5'h01, 5'(skipDefeat));
        chk("twenty", 5'h00, 5'(twentyProg));
        host.send(5'h05);
        chk("powerOn", 5'h00, 5'(powerOn));
        kb(2);
        chk("prog", 5'h01, progNum);
        for (int i = 0; i < 4; i++) begin
            host.send(avProg[i]);
            chk("avOe", avExp[i], 5'({avFirstOe, avSecondOe}));
        end
        host.send(5'h0d);
        chk("prog", 5'h0d, progNum);
        host.send(5'h10);
        chk("prog", 5'h10, progNum);
        kb(2);
        chk("powerOn", 5'h00, 5'(powerOn));
        $display("test sixteen program done");
        // twenty programs, standby power-up, prefix mode, keyboard commands, all bands skipped
        bandSkip_b = 4'h0;
        rst(5'h0d);
        chk("decade", 5'h00, 5'(decadeMode));
        host.send(5'h0d);
        chk("prog", 5'h01, progNum);
        kb(0);
        chk("band", 5'h01, 5'(bandSel));
        bandSkip_b = 4'hf;
        kc(5'h0d);
        host.send(5'h03);
        chk("prog", 5'h0d, progNum);
        kc(5'h0c);
        chk("prog", 5'h0d, progNum);
        kc(5'h0d);
        kc(5'h0a);
        chk("prog", 5'h0a, progNum);
        kb(0);
        chk("band", 5'h02, 5'(bandSel));
        kc(5'h1d);
        chk("standby", 5'h01, 5'(standbyOut));
        $display("test prefix keyboard done");
        finish_test();
    end
endmodule : tvc_top_tb
